// ### core/txs_tx_status.sv
// Transmit outcome flags with an APB register port.
// Assumes the transmit engine and receive monitor give pulses on pclk;
// carrier sense arrives from the transceiver pin, asynchronous.
//
// Overview of operation
// - Set deferred flag when the first attempt had to wait.
// - Clear deferred flag when a later collision occurs.
// - Clear deferred and late flags after status word write-back.
// - No-carrier set at preamble start, cleared when carrier seen.
// - Watch carrier from delimiter to last byte; never abort for it.
// - Set carrier-lost whenever carrier low during the watched span.
// - Missing carrier reports no-carrier and carrier-lost together.
// - MAC loopback always reports no-carrier and carrier-lost set.
// - Sixteen collisions abort and set excess-collision flag.
// - Collision after one slot time sets late flag; back off normally.
// - Monitored-bad on CRC, alignment or unmatched source address.
// - CRC checker stays running while transmitting.
// - With FCS suppressed, monitored-bad stays low.
// - Transmit FIFO empty before refill aborts and sets underrun.
// - Total length unequal to fragment sum aborts, sets mismatch.
// - Window origin bit: 0 after delimiter, 1 after first preamble bit.
// - FCS suppress bit: 0 appends 4-byte FCS, 1 omits it.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
module txs_tx_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic carrier_sense,
  input wire logic pkt_start,
  input wire logic preamble_start,
  input wire logic sfd_end,
  input wire logic last_byte_done,
  input wire logic defer_wait,
  input wire logic collision,
  input wire logic fifo_starved,
  input wire logic frag_valid,
  input wire logic frag_last,
  input wire logic [15:0] tx_desc_fragment_length,
  input wire logic [15:0] tx_desc_total_length,
  input wire logic monitor_done,
  input wire logic mon_crc_bad,
  input wire logic mon_align_err,
  input wire logic mon_sa_miss,
  input wire logic status_written,
  input wire logic rx_fifo_overflow_flag,
  output logic tx_abort,
  output logic fcs_append,
  output logic crc_check_en,
  output logic mac_loopback,
  output logic [15:0] tx_desc_status_word,
  output logic [4:0] collision_count
);
  import txs_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] idx);
    addr_hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx[5:0]);
  endfunction : addr_hit

  function automatic logic [15:0] field(input logic val, input int pos);
    field = 16'(val) << pos;
  endfunction : field

  // ----------------------------------------------------------------
  // Carrier sense synchroniser
  // ----------------------------------------------------------------
  logic crs_meta_r;
  logic crs_sync_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crs_meta_r <= 1'b0;
      crs_sync_r <= 1'b0;
    end else begin
      crs_meta_r <= carrier_sense;
      crs_sync_r <= crs_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [TXS_REG_W-1:0] ctrl_r;
  logic [TXS_REG_W-1:0] ctrl_nxt;
  logic loop_r;
  logic loop_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;

  wire hit_ctrl = addr_hit(paddr, TXS_CTRL_STAT_IDX);
  wire hit_mode = addr_hit(paddr, TXS_MODE_IDX);
  wire hit_any = hit_ctrl | hit_mode;
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;

  assign pready = psel & penable;
  assign ctrl_nxt = (apb_wr && hit_ctrl) ? (pwdata[15:0] & TXS_CTRL_WMASK) : ctrl_r;
  assign loop_nxt = (apb_wr && hit_mode) ? pwdata[TXS_B_LOOP] : loop_r;

  wire late_window_origin = ctrl_r[TXS_B_ORIGIN];
  wire fcs_suppress = ctrl_r[TXS_B_FCS_SUP];

  // ----------------------------------------------------------------
  // Packet sequencing
  // ----------------------------------------------------------------
  txs_state_e state_r;
  txs_state_e state_nxt;
  logic [4:0] coll_cnt_r;
  logic [4:0] coll_cnt_nxt;
  logic [15:0] frag_sum_r;
  logic [15:0] frag_sum_nxt;
  logic abort_r;
  logic abort_nxt;
  logic crc_en_r;
  logic crc_en_nxt;

  wire in_attempt = (state_r == TXS_ST_PRE) || (state_r == TXS_ST_FRAME);
  wire watching = (state_r == TXS_ST_FRAME);
  // Collisions and starvation outside an attempt are refused
  wire coll_evt = collision & in_attempt;
  wire [4:0] coll_inc = coll_cnt_r + 5'h01;
  wire coll_limit_hit = coll_evt && (coll_inc == TXS_COLL_LIMIT);
  wire [15:0] frag_total = frag_sum_r + tx_desc_fragment_length;
  wire mismatch_hit = frag_valid && frag_last && (frag_total != tx_desc_total_length);
  wire underrun_hit = fifo_starved & in_attempt;
  wire abort_hit = coll_limit_hit | underrun_hit | mismatch_hit;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TXS_ST_IDLE: begin
        if (preamble_start) begin
          state_nxt = TXS_ST_PRE;
        end
      end
      TXS_ST_PRE: begin
        if (abort_hit || coll_evt) begin
          state_nxt = TXS_ST_IDLE;
        end else if (sfd_end) begin
          state_nxt = TXS_ST_FRAME;
        end
      end
      TXS_ST_FRAME: begin
        if (abort_hit || coll_evt) begin
          state_nxt = TXS_ST_IDLE;
        end else if (last_byte_done) begin
          state_nxt = TXS_ST_DONE;
        end
      end
      TXS_ST_DONE: begin
        if (pkt_start || preamble_start) begin
          state_nxt = pkt_start ? TXS_ST_IDLE : TXS_ST_PRE;
        end
      end
      default: begin
        state_nxt = TXS_ST_IDLE;
      end
    endcase
  end

  // Collisions count per packet; a new packet restarts the count
  assign coll_cnt_nxt = pkt_start ? 5'h00 : (coll_evt ? coll_inc : coll_cnt_r);
  assign frag_sum_nxt = (pkt_start || (frag_valid && frag_last)) ? 16'h0000
                      : (frag_valid ? frag_total : frag_sum_r);
  assign abort_nxt = abort_hit;

  // Checker enable follows the next state, so it is on from the first preamble cycle
  // and is held after the last byte only until the monitor reports
  wire attempt_nxt = (state_nxt == TXS_ST_PRE) || (state_nxt == TXS_ST_FRAME);
  wire crc_hold = crc_en_r && (state_nxt == TXS_ST_DONE) && !monitor_done;
  assign crc_en_nxt = attempt_nxt || crc_hold;

  // ----------------------------------------------------------------
  // Slot timer
  // ----------------------------------------------------------------
  txs_slot_if slot_bus ();

  assign slot_bus.start = late_window_origin ? preamble_start : sfd_end;
  // Any end of the attempt closes the late-collision window
  assign slot_bus.stop = pkt_start | abort_hit | coll_evt | last_byte_done;

  txs_slot_timer u_slot (
    .pclk(pclk),
    .presetn(presetn),
    .slot(slot_bus)
  );

  // ----------------------------------------------------------------
  // Outcome flags
  // ----------------------------------------------------------------
  logic deferred_flag_r;
  logic no_carrier_flag_r;
  logic carrier_lost_flag_r;
  logic excess_collision_flag_r;
  logic late_collision_flag_r;
  logic monitored_bad_flag_r;
  logic tx_underrun_flag_r;
  logic length_mismatch_flag_r;
  logic pkt_ok_r;
  logic deferred_nxt;
  logic no_carrier_nxt;
  logic carrier_lost_nxt;
  logic excess_nxt;
  logic late_nxt;
  logic mbad_nxt;
  logic underrun_nxt;
  logic mismatch_nxt;
  logic pkt_ok_nxt;

  // Sets win over clears; a packet start clears only what has no set pending
  wire def_set = defer_wait && (coll_cnt_r == 5'h00) && !coll_evt;
  wire def_clr = coll_evt | status_written | pkt_start;
  assign deferred_nxt = def_set | (deferred_flag_r & ~def_clr);

  // Loopback forces both carrier flags on every cycle
  wire no_carrier_flag_set = preamble_start | loop_r;
  wire no_carrier_flag_clr = (watching && crs_sync_r) | pkt_start;
  assign no_carrier_nxt = no_carrier_flag_set | (no_carrier_flag_r & ~no_carrier_flag_clr);

  // Absent carrier keeps both flags set together
  wire clost_set = (watching && !crs_sync_r) | loop_r;
  assign carrier_lost_nxt = clost_set | (carrier_lost_flag_r & ~pkt_start);

  assign excess_nxt = coll_limit_hit | (excess_collision_flag_r & ~pkt_start);

  wire late_set = coll_evt & slot_bus.expired;
  wire late_clr = status_written | pkt_start;
  assign late_nxt = late_set | (late_collision_flag_r & ~late_clr);

  wire mon_err = mon_crc_bad | mon_align_err | mon_sa_miss;
  wire mbad_set = monitor_done && mon_err && !fcs_suppress;
  assign mbad_nxt = mbad_set | (monitored_bad_flag_r & ~pkt_start & ~fcs_suppress);

  assign underrun_nxt = underrun_hit | (tx_underrun_flag_r & ~pkt_start);
  assign mismatch_nxt = mismatch_hit | (length_mismatch_flag_r & ~pkt_start);

  // A fatal cause keeps the packet-ok bit low and clears it if already set
  wire fatal_seen = excess_collision_flag_r | tx_underrun_flag_r | length_mismatch_flag_r;
  wire ok_set = watching && last_byte_done && !fatal_seen && !abort_hit;
  assign pkt_ok_nxt = ok_set | (pkt_ok_r & ~pkt_start & ~abort_hit);

  // ----------------------------------------------------------------
  // Status word and read data
  // ----------------------------------------------------------------
  // The status word mirrors the register, so a write-back copies it unchanged
  wire [15:0] status_word = field(late_window_origin, TXS_B_ORIGIN)
                          | field(fcs_suppress, TXS_B_FCS_SUP)
                          | field(deferred_flag_r, TXS_B_DEF)
                          | field(no_carrier_flag_r, TXS_B_NO_CARRIER_FLAG)
                          | field(carrier_lost_flag_r, TXS_B_CLOST)
                          | field(excess_collision_flag_r, TXS_B_EXC)
                          | field(late_collision_flag_r, TXS_B_LATE)
                          | field(monitored_bad_flag_r, TXS_B_MBAD)
                          | field(tx_underrun_flag_r, TXS_B_UNDR)
                          | field(length_mismatch_flag_r, TXS_B_LMIS)
                          | field(pkt_ok_r, TXS_B_OK);

  // Read data and error are captured in the setup cycle, so they are valid in the access cycle
  assign prdata_nxt = !apb_setup ? prdata
                    : (hit_ctrl ? {16'h0000, status_word}
                    : (hit_mode ? {31'h00000000, loop_r} : 32'h00000000));
  // Unaligned or unmapped addresses answer with an error and read as zero
  assign pslverr_nxt = apb_setup ? !hit_any : pslverr;

  assign tx_abort = abort_r;
  assign fcs_append = !fcs_suppress;
  assign crc_check_en = crc_en_r;
  assign mac_loopback = loop_r;
  assign tx_desc_status_word = status_word;
  assign collision_count = coll_cnt_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= TXS_CTRL_RST;
      loop_r <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      loop_r <= loop_nxt;
      prdata <= prdata_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TXS_ST_IDLE;
      coll_cnt_r <= 5'h00;
      frag_sum_r <= 16'h0000;
      abort_r <= 1'b0;
      crc_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      coll_cnt_r <= coll_cnt_nxt;
      frag_sum_r <= frag_sum_nxt;
      abort_r <= abort_nxt;
      crc_en_r <= crc_en_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deferred_flag_r <= 1'b0;
      no_carrier_flag_r <= 1'b0;
      carrier_lost_flag_r <= 1'b0;
      excess_collision_flag_r <= 1'b0;
      late_collision_flag_r <= 1'b0;
      monitored_bad_flag_r <= 1'b0;
      tx_underrun_flag_r <= 1'b0;
      length_mismatch_flag_r <= 1'b0;
      pkt_ok_r <= 1'b0;
    end else begin
      deferred_flag_r <= deferred_nxt;
      no_carrier_flag_r <= no_carrier_nxt;
      carrier_lost_flag_r <= carrier_lost_nxt;
      excess_collision_flag_r <= excess_nxt;
      late_collision_flag_r <= late_nxt;
      monitored_bad_flag_r <= mbad_nxt;
      tx_underrun_flag_r <= underrun_nxt;
      length_mismatch_flag_r <= mismatch_nxt;
      pkt_ok_r <= pkt_ok_nxt;
    end
  end

  // rx_fifo_overflow_flag is left unused; it is not passed on and plays no part in monitored-bad
  wire unused_ok = rx_fifo_overflow_flag;

endmodule : txs_tx_status

// ### core/txs_pkg.sv
// Constants and types shared by the transmit status block.
// Assumes a 20 MHz pclk and a 32-bit APB register port.
package txs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TXS_CTRL_STAT_IDX = 8'h03;
  localparam logic [7:0] TXS_MODE_IDX = 8'h04;
  localparam int TXS_REG_W = 16;
  localparam logic [15:0] TXS_CTRL_RST = 16'h0000;
  localparam logic [15:0] TXS_CTRL_WMASK = 16'h6000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TXS_B_ORIGIN = 14;
  localparam int TXS_B_FCS_SUP = 13;
  localparam int TXS_B_DEF = 9;
  localparam int TXS_B_NO_CARRIER_FLAG = 8;
  localparam int TXS_B_CLOST = 7;
  localparam int TXS_B_EXC = 6;
  localparam int TXS_B_LATE = 5;
  localparam int TXS_B_MBAD = 3;
  localparam int TXS_B_UNDR = 2;
  localparam int TXS_B_LMIS = 1;
  localparam int TXS_B_OK = 0;
  localparam int TXS_B_LOOP = 0;

  // ----------------------------------------------------------------
  // Timing and counts
  // ----------------------------------------------------------------
  localparam real TXS_SLOT_TIME_US = 51.2;
  localparam real TXS_PCLK_MHZ = 20.0;
  localparam int TXS_SLOT_CYCLES = int'($ceil(TXS_SLOT_TIME_US * TXS_PCLK_MHZ));
  localparam int TXS_SLOT_CW = 11;
  localparam logic [4:0] TXS_COLL_LIMIT = 5'h10;

  typedef enum logic [1:0] {
    TXS_ST_IDLE = 2'b00,
    TXS_ST_PRE = 2'b01,
    TXS_ST_FRAME = 2'b10,
    TXS_ST_DONE = 2'b11
  } txs_state_e;

endpackage : txs_pkg

// ### core/txs_slot_if.sv
// Carrier between the status core and its slot timer.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface txs_slot_if;
  logic start;
  logic stop;
  logic expired;
  modport core (output start, output stop, input expired);
  modport timer (input start, input stop, output expired);
endinterface : txs_slot_if

// ### core/txs_slot_timer.sv
// One slot time counter for late collision detection.
// Assumes start and stop are single-cycle pulses on pclk.
`timescale 1ns/10ps
module txs_slot_timer (
  input wire logic pclk,
  input wire logic presetn,
  txs_slot_if.timer slot
);
  import txs_pkg::*;

  localparam logic [TXS_SLOT_CW-1:0] TXS_SLOT_LAST = TXS_SLOT_CW'(TXS_SLOT_CYCLES - 1);

  logic [TXS_SLOT_CW-1:0] cnt_r;
  logic [TXS_SLOT_CW-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic exp_r;
  logic exp_nxt;
  wire at_end = run_r && (cnt_r == TXS_SLOT_LAST);

  // Restart wins over stop so a new attempt always opens a fresh window
  assign run_nxt = slot.start | (run_r & ~slot.stop & ~at_end);
  assign cnt_nxt = slot.start ? '0 : (run_r ? cnt_r + 1'b1 : cnt_r);
  assign exp_nxt = ~slot.start & ~slot.stop & (exp_r | at_end);
  assign slot.expired = exp_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

endmodule : txs_slot_timer

// ### verification/txs_xcvr_model.sv
// Transceiver stand-in that returns carrier sense while the MAC sends.
// Assumes tx_on is high from first preamble bit to last byte.
`timescale 1ns/10ps
module txs_xcvr_model (
  input wire logic pclk,
  input wire logic tx_on,
  input wire logic present,
  input wire logic drop,
  output logic carrier_sense
);
  initial carrier_sense = 1'b0;
  // Carrier idles low outside frames; it can be withheld or dropped
  always @(posedge pclk) begin
    carrier_sense <= tx_on && present && !drop;
  end
endmodule : txs_xcvr_model

// ### verification/txs_tx_status_chk.sv
// Port assertions for the transmit status block.
// Assumes pulse inputs last one pclk cycle; bound at the foot.
`timescale 1ns/10ps
module txs_tx_status_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic carrier_sense,
  input wire logic pkt_start,
  input wire logic preamble_start,
  input wire logic sfd_end,
  input wire logic last_byte_done,
  input wire logic defer_wait,
  input wire logic collision,
  input wire logic status_written,
  input wire logic mac_loopback,
  input wire logic tx_abort,
  input wire logic fcs_append,
  input wire logic crc_check_en,
  input wire logic [15:0] tx_desc_status_word,
  input wire logic [4:0] collision_count
);
  import txs_pkg::*;
  logic [15:0] w;
  assign w = tx_desc_status_word;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Follows whether an attempt is open, from preamble start to its end
  logic att_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      att_r <= 1'b0;
    end else begin
      att_r <= (preamble_start & ~att_r) | (att_r & ~last_byte_done & ~collision & ~tx_abort);
    end
  end
  // ----------------------------------------------------------------
  // Flag behaviour
  // ----------------------------------------------------------------
  sequence unwatched_s;
    sfd_end ##1 (!carrier_sense && !last_byte_done && !collision)[*4];
  endsequence
  sequence attempt_hit_s;
    collision && att_r && !tx_abort && !defer_wait;
  endsequence
  defer_set_a: assert property (defer_wait && !collision && collision_count == 5'h00
    |=> w[TXS_B_DEF]) else $error("deferred not set");
  defer_clear_a: assert property (attempt_hit_s |=> !w[TXS_B_DEF]) else $error("deferred kept");
  wb_clear_a: assert property (status_written && !collision && !defer_wait
    |=> !w[TXS_B_DEF] && !w[TXS_B_LATE]) else $error("write-back clear missed");
  no_carrier_flag_set_a: assert property (preamble_start |=> w[TXS_B_NO_CARRIER_FLAG]) else $error("no carrier not set");
  crs_lost_a: assert property (unwatched_s |-> ##[0:3] w[TXS_B_CLOST]) else $error("carrier lost missed");
  both_flags_a: assert property (last_byte_done && w[TXS_B_NO_CARRIER_FLAG] |-> w[TXS_B_CLOST])
    else $error("carrier flags apart");
  loop_flags_a: assert property (mac_loopback && $past(mac_loopback)
    |-> w[TXS_B_NO_CARRIER_FLAG] && w[TXS_B_CLOST]) else $error("loopback flags low");
  abort_cause_a: assert property ($rose(w[TXS_B_EXC]) || $rose(w[TXS_B_UNDR]) || $rose(w[TXS_B_LMIS])
    |-> tx_abort) else $error("abort missing");
  crc_on_a: assert property (preamble_start |=> crc_check_en) else $error("checker idle");
  fcs_follow_a: assert property (fcs_append == !w[TXS_B_FCS_SUP]) else $error("fcs append wrong");
  inhibit_bad_a: assert property (w[TXS_B_FCS_SUP] && $past(w[TXS_B_FCS_SUP]) |-> !w[TXS_B_MBAD])
    else $error("monitored bad with fcs off");
  fresh_pkt_a: assert property (pkt_start && !mac_loopback && !defer_wait |=> w[9:1] == 9'h000)
    else $error("flags survive new packet");
  excess_count_a: assert property ($rose(w[TXS_B_EXC]) |-> collision_count == TXS_COLL_LIMIT)
    else $error("collision count not at limit");
  count_clear_a: assert property (pkt_start |=> collision_count == 5'h00) else $error("collision count kept");
endmodule : txs_tx_status_chk

bind txs_tx_status txs_tx_status_chk chk (.pclk, .presetn, .carrier_sense, .pkt_start, .preamble_start, .sfd_end,
  .last_byte_done, .defer_wait, .collision, .status_written, .mac_loopback, .tx_abort, .fcs_append,
  .crc_check_en, .tx_desc_status_word, .collision_count);

// ### verification/txs_tx_status_tb.sv
// Self-checking bench for the transmit status block.
// Assumes the checker binds itself; reads are compared by a monitor.
`timescale 1ns/10ps
module txs_tx_status_tb;
  import txs_pkg::*;
`define CMP(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", n, e, s); end end
  localparam int PK = 1, PR = 2, SF = 4, LB = 8, DF = 16, CO = 32, ST = 64, MD = 128, SW = 256, FV = 512, FL = 1024;
  localparam logic [7:0] CA = TXS_CTRL_STAT_IDX << 2, MA = TXS_MODE_IDX << 2;
  localparam logic [31:0] DEF = 32'h1 << TXS_B_DEF, NC = 32'h1 << TXS_B_NO_CARRIER_FLAG, CL = 32'h1 << TXS_B_CLOST;
  localparam logic [31:0] EXCESS_COLLISION_FLAG = 32'h1 << TXS_B_EXC, LT = 32'h1 << TXS_B_LATE, MB = 32'h1 << TXS_B_MBAD;
  localparam logic [31:0] UN = 32'h1 << TXS_B_UNDR, LM = 32'h1 << TXS_B_LMIS, OK = 32'h1 << TXS_B_OK;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, crs;
  logic tx_on = 0, present = 1, drop = 0, ovf = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [10:0] p = 0;
  logic [2:0] mon = 0;
  logic [15:0] flen = 0, tlen = 0, s;
  logic [15:0] fr[3];
  logic [64:0] q[$], n;
  int errors = 0, checks = 0, seed = 46073;
  always #25 pclk = ~pclk;
  txs_tx_status uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .carrier_sense(crs),
    .pkt_start(p[0]), .preamble_start(p[1]), .sfd_end(p[2]), .last_byte_done(p[3]), .defer_wait(p[4]),
    .collision(p[5]), .fifo_starved(p[6]), .monitor_done(p[7]), .status_written(p[8]), .frag_valid(p[9]),
    .frag_last(p[10]), .tx_desc_fragment_length(flen), .tx_desc_total_length(tlen), .mon_crc_bad(mon[0]),
    .mon_align_err(mon[1]), .mon_sa_miss(mon[2]), .rx_fifo_overflow_flag(ovf), .tx_abort(), .fcs_append(),
    .crc_check_en(), .mac_loopback(), .tx_desc_status_word(), .collision_count());
  txs_xcvr_model xcvr (.pclk(pclk), .tx_on(tx_on), .present(present), .drop(drop), .carrier_sense(crs));
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    q.push_back({1'(a != CA && a != MA), m, e});
    apb(0, a, 32'h0);
  endtask : rd
  task automatic ev(input int m);
    p <= m[10:0];
    @(posedge pclk);
    p <= 0;
    @(posedge pclk);
  endtask : ev
  task automatic pkt(input logic dfr, input int body);
    ev(PK);
    if (dfr) ev(DF);
    tx_on <= 1;
    ev(PR);
    tick(3);
    ev(SF);
    tick(body);
  endtask : pkt
  task automatic fin;
    ev(LB);
    tx_on <= 0;
  endtask : fin
  task automatic close_out;
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Read results are matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n = q.pop_front();
      `CMP("prdata", n[31:0], prdata & n[63:32])
      `CMP("pslverr", n[64], pslverr)
    end
  end
  initial begin
    repeat (8000) @(posedge pclk);
    errors++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(CA, '1, 32'h0);
    rd(MA, '1, 32'h0);
    apb(1, 8'h08, '1);
    rd(8'h08, '1, 32'h0);
    rd(CA | 8'h01, '1, 32'h0);
    pkt(1, 8); fin(); rd(CA, '1, DEF | OK);
    ev(SW); rd(CA, '1, OK);
    present <= 0; pkt(0, 8); fin(); rd(CA, '1, NC | CL | OK);
    present <= 1; pkt(0, 8); drop <= 1; tick(6); drop <= 0; fin(); rd(CA, '1, CL | OK);
    pkt(1, 2); ev(CO); ev(PR); tick(3); ev(SF); tick(8); fin(); rd(CA, '1, OK);
    pkt(0, 2); repeat (15) begin ev(CO); ev(PR); end
    ev(CO); tx_on <= 0; rd(CA, ~(NC | CL), EXCESS_COLLISION_FLAG);
    for (int o = 0; o < 2; o++) begin
      apb(1, CA, 32'(o) << TXS_B_ORIGIN);
      ev(PK); tx_on <= 1; ev(PR); tick(18); ev(SF); tick(1008); ev(CO);
      rd(CA, LT, o ? LT : 32'h0);
      ev(SW); tx_on <= 0; rd(CA, LT, 32'h0);
    end
    apb(1, CA, 32'h0); pkt(0, 2); ev(ST); tx_on <= 0; rd(CA, UN | OK, UN);
    for (int k = 0; k < 2; k++) begin
      s = 16'h0000;
      foreach (fr[i]) begin fr[i] = 16'($random(seed)) & 16'h07FF; s = s + fr[i]; end
      tlen <= s + 16'(k);
      ev(PK);
      foreach (fr[i]) begin flen <= fr[i]; ev(i == 2 ? FV | FL : FV); end
      rd(CA, LM, k ? LM : 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      ev(PK);
      if (k == 3) apb(1, CA, 32'h1 << TXS_B_FCS_SUP);
      mon <= 3'b001 << (k % 3); ovf <= 1'($random(seed));
      ev(MD);
      rd(CA, MB, k < 3 ? MB : 32'h0);
    end
    apb(1, CA, 32'h0); apb(1, MA, 32'h1); ev(PK); rd(CA, NC | CL, NC | CL);
    rd(MA, '1, 32'h1); apb(1, MA, 32'h0); ev(PK); rd(CA, '1, 32'h0);
    close_out();
  end
endmodule : txs_tx_status_tb
